// File: src/scmc_pkg.sv
// Purpose: shared constants and types for the system clock / mode control
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: all offsets, writable field positions and register reset values live here
package scmc_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_MODE_CTRL = 8'h00; // mode_control_register
	localparam logic [7:0] ADDR_SYS_CTRL = 8'h04; // idle clock / pll bits
	localparam logic [7:0] ADDR_STATUS = 8'h08; // operating mode, read only
	localparam logic [7:0] ADDR_CONFIG = 8'h0C; // configuration options

	// mode_control_register fields
	localparam int MC_HI_LO_CLOCK_SELECT_BIT = 0; // hi_lo_clock_select
	localparam int MC_IDLE_ON_HALT_ENABLE_BIT = 1; // idle_on_halt_enable
	localparam int MC_FSTEN_BIT = 4; // fast wake enable
	localparam int MC_DIV_LSB = 5; // divider_select lsb
	localparam logic [7:0] MC_RESET = 8'h03;
	localparam logic [7:0] MC_WMASK = 8'hF3;

	// system control fields
	localparam int SC_FSYS_BIT = 0; // sysclk_in_idle_enable
	localparam int SC_LVD_BIT = 1; // low_voltage_detect_enable
	localparam int SC_WDT_BIT = 2; // watchdog enable
	localparam int SC_PLL_BIT = 3; // pll bypass bit
	localparam int SC_USB_BIT = 4; // usb_clock_enable
	localparam int SC_16M_BIT = 5; // sysclk_16mhz_select
	localparam logic [7:0] SC_RESET = 8'h00;

	// configuration option fields
	localparam int CF_HOSC_BIT = 0; // 1: crystal, 0: internal rc
	localparam int CF_LOSC_BIT = 1; // low path: 1 crystal, 0 rc
	localparam int CF_SUB_BIT = 2; // substitute clock: 1 crystal
	localparam int CF_TBC_BIT = 3; // time base clock: 1 crystal
	localparam int CF_NOTBC_BIT = 4; // variant without time base clock
	localparam logic [7:0] CF_RESET = 8'h00;

	// divider
	localparam int DIV_W = 6; // counts up to a ratio of 64
	localparam logic [DIV_W-1:0] DIV_RESET = 6'h00;

	// operating modes
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_SLOW,
		MODE_IDLE_STOP,
		MODE_IDLE_RUN,
		MODE_DEEP_SLEEP,
		MODE_LIGHT_SLEEP
	} scmc_mode_t;

	// clock enables bundled toward the rest of the chip
	typedef struct packed {
		logic cpu; // cpu clock runs
		logic sys; // system clock to peripherals
		logic sub; // substitute clock runs
		logic tbc; // time base clock runs
		logic hosc; // high speed oscillator enabled
	} scmc_gate_t;

	localparam scmc_gate_t GATE_RESET = 5'h1F;

endpackage : scmc_pkg

// File: src/scmc_div.sv
// Purpose: free-running divider of the high speed clock
// Assumes: i_clk_h is an in-domain enable-style clock level
// Notes: taps give /2 to /64 by counter bits
`timescale 1ns/1ps
module scmc_div (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_clk_h,
	input wire logic i_run,
	output logic [5:0] o_taps
);
	logic prev_ff; // last level of the source
	logic [scmc_pkg::DIV_W-1:0] cnt_ff; // ripple count on source edges
	logic [scmc_pkg::DIV_W-1:0] nxt_cnt;
	wire rise = i_clk_h & ~prev_ff; // source rising edge

	// stopped oscillator freezes the count, which also saves power
	assign nxt_cnt = !i_run ? cnt_ff :
		(rise ? cnt_ff + 6'h01 : cnt_ff);

	// edge memory and count
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_ff <= 1'b0;
			cnt_ff <= scmc_pkg::DIV_RESET;
		end else begin
			prev_ff <= i_clk_h;
			cnt_ff <= nxt_cnt;
		end
	end

	// bit k toggles every 2^k source edges... at ratio 2^(k+1)
	assign o_taps = cnt_ff;
endmodule : scmc_div

// File: src/scmc_top.sv
// Purpose: system clock source selection and low power mode control
// Assumes: oscillators arrive as sampled levels on i_mclk
// Notes: clocks out are levels derived from sampled sources
// Summary of operation
// - sysclock from high or low path
// - high source: crystal, pll or rc
// - divided high clock, ratios two to 64
// - substitute and time base source by option
// - substitute clock used right after wake
// - going to low path stops high oscillator
// - substitute clock offered to watchdog
// - time base clock to timers, else low
// - six modes: normal, slow, four halted
// - normal runs high clock divided 1 to 64
// - slow runs low clock, high off
// - halt, idle off: deep sleep stops substitute
// - low voltage detect set blocks deep sleep
// - detect or watchdog on gives light sleep
// - idle, sysclock off: oscillator stops, sub on
// - idle stopped: cpu off, peripherals alive
// - idle running: system clock keeps peripherals
// - divider codes: low, then /64 to /2
// - hi select gives undivided high clock
// - high clock chosen by pll, usb, 16 MHz bits
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module scmc_top (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_hxt, // high_speed_crystal level
	input wire logic i_high_speed_internal_rc, // high_speed_internal_rc level
	input wire logic i_pll_16m, // pll 16 MHz output
	input wire logic i_pll_usb, // pll 6 or 12 MHz output
	input wire logic i_lxt, // low_speed_crystal level
	input wire logic i_low_speed_internal_rc, // low_speed_internal_rc level
	input wire logic i_halt, // halt instruction executed, pulse
	input wire logic i_wake, // wake-up event, pulse
	input wire logic i_hosc_ready, // high oscillator stable after wake
	output logic o_sys_clk, // system clock level
	output logic o_sub_clk, // substitute clock, also watchdog source
	output logic o_tbc_clk, // time base clock to timers
	output logic o_fast_wake, // running on substitute after wake
	output logic o_wdt_enable, // watchdog function allowed
	output scmc_pkg::scmc_gate_t o_gate, // clock enables
	output scmc_pkg::scmc_mode_t o_mode // current operating mode
);
	logic [7:0] mc_ff; // mode_control_register
	logic [7:0] sc_ff; // system control bits
	logic [7:0] cf_ff; // configuration options
	scmc_pkg::scmc_mode_t mode_ff;
	scmc_pkg::scmc_mode_t nxt_mode;
	logic fast_ff; // substitute clock stands in after wake
	logic nxt_fast;
	logic sys_ff, sub_ff, tbc_ff; // registered clock outputs
	scmc_pkg::scmc_gate_t gate_ff;
	scmc_pkg::scmc_gate_t nxt_gate;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// field views
	wire hi_lo_clock_select = mc_ff[scmc_pkg::MC_HI_LO_CLOCK_SELECT_BIT];
	wire idle_on_halt_enable = mc_ff[scmc_pkg::MC_IDLE_ON_HALT_ENABLE_BIT];
	wire fsten = mc_ff[scmc_pkg::MC_FSTEN_BIT];
	wire [2:0] divsel = mc_ff[scmc_pkg::MC_DIV_LSB +: 3];
	wire sysclk_in_idle_enable = sc_ff[scmc_pkg::SC_FSYS_BIT];
	wire low_voltage_detect_enable = sc_ff[scmc_pkg::SC_LVD_BIT];
	wire wdten = sc_ff[scmc_pkg::SC_WDT_BIT];
	wire pll = sc_ff[scmc_pkg::SC_PLL_BIT];
	wire usben = sc_ff[scmc_pkg::SC_USB_BIT];
	wire sel16 = sc_ff[scmc_pkg::SC_16M_BIT];

	// apb decode: zero wait states, unmapped address errors
	wire acc = i_psel & i_penable;
	wire hit_mc = i_paddr == scmc_pkg::ADDR_MODE_CTRL;
	wire hit_sc = i_paddr == scmc_pkg::ADDR_SYS_CTRL;
	wire hit_st = i_paddr == scmc_pkg::ADDR_STATUS;
	wire hit_cf = i_paddr == scmc_pkg::ADDR_CONFIG;
	wire mapped = hit_mc | hit_sc | hit_st | hit_cf;
	wire wr = acc & i_pwrite & mapped;
	assign o_pready = 1'b1;
	assign o_pslverr = acc & ~mapped;

	// high oscillator source by option and control bits
	wire hosc = cf_ff[scmc_pkg::CF_HOSC_BIT] ? i_hxt : i_high_speed_internal_rc;
	wire use_osc = pll | (~usben & ~sel16);
	wire clk_h = use_osc ? hosc :
		(sel16 ? i_pll_16m : i_pll_usb);
	wire clk_l = cf_ff[scmc_pkg::CF_LOSC_BIT] ? i_lxt : i_low_speed_internal_rc;
	wire clk_sub = cf_ff[scmc_pkg::CF_SUB_BIT] ? i_lxt : i_low_speed_internal_rc;
	wire clk_tbc_src = cf_ff[scmc_pkg::CF_NOTBC_BIT] ? clk_l :
		(cf_ff[scmc_pkg::CF_TBC_BIT] ? i_lxt : i_low_speed_internal_rc);

	// low path chosen means high oscillator is off
	wire low_path = ~hi_lo_clock_select & (divsel[2:1] == 2'b00);
	wire [5:0] taps;
	scmc_div u_div (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_clk_h(clk_h),
		.i_run(gate_ff.hosc),
		.o_taps(taps)
	);
	// code 010 -> /64 (tap 5) ... 111 -> /2 (tap 0)
	wire [2:0] tap_idx = 3'd7 - divsel;
	wire div_clk = taps[tap_idx];
	wire sel_clk = hi_lo_clock_select ? clk_h :
		(low_path ? clk_l : div_clk);

	// halt decode into the four stopped modes
	wire deep_ok = ~low_voltage_detect_enable & ~wdten;
	wire halted = (mode_ff == scmc_pkg::MODE_NORMAL) |
		(mode_ff == scmc_pkg::MODE_SLOW);
	wire slow_now = low_path;

	// next mode
	always_comb begin
		nxt_mode = mode_ff;
		nxt_fast = fast_ff;
		if (halted) begin
			nxt_mode = slow_now ? scmc_pkg::MODE_SLOW :
				scmc_pkg::MODE_NORMAL;
			if (fast_ff && (i_hosc_ready || slow_now)) begin
				nxt_fast = 1'b0; // original oscillator stable
			end
			if (i_halt) begin
				if (!idle_on_halt_enable) begin
					nxt_mode = deep_ok ?
						scmc_pkg::MODE_DEEP_SLEEP :
						scmc_pkg::MODE_LIGHT_SLEEP;
				end else if (!sysclk_in_idle_enable) begin
					nxt_mode = scmc_pkg::MODE_IDLE_STOP;
				end else begin
					nxt_mode = scmc_pkg::MODE_IDLE_RUN;
				end
			end
		end else if (i_wake) begin
			nxt_mode = slow_now ? scmc_pkg::MODE_SLOW :
				scmc_pkg::MODE_NORMAL;
			// substitute stand-in only where it kept running
			nxt_fast = fsten & ~slow_now &
				((mode_ff == scmc_pkg::MODE_LIGHT_SLEEP) |
				(mode_ff == scmc_pkg::MODE_IDLE_STOP));
		end
	end

	// clock gates per mode
	always_comb begin
		nxt_gate = '0;
		unique case (nxt_mode)
			scmc_pkg::MODE_NORMAL: begin
				nxt_gate = 5'h1F;
			end
			scmc_pkg::MODE_SLOW: begin
				nxt_gate = 5'h1E;
			end
			scmc_pkg::MODE_IDLE_STOP: begin
				nxt_gate.sub = 1'b1;
				nxt_gate.tbc = 1'b1;
			end
			scmc_pkg::MODE_IDLE_RUN: begin
				nxt_gate.sys = 1'b1;
				nxt_gate.sub = 1'b1;
				nxt_gate.tbc = 1'b1;
				nxt_gate.hosc = ~slow_now;
			end
			scmc_pkg::MODE_DEEP_SLEEP: begin
				nxt_gate = '0;
			end
			scmc_pkg::MODE_LIGHT_SLEEP: begin
				nxt_gate.sub = 1'b1;
			end
		endcase
	end

	// mode and gate state
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_ff <= scmc_pkg::MODE_NORMAL;
			fast_ff <= 1'b0;
			gate_ff <= scmc_pkg::GATE_RESET;
		end else begin
			mode_ff <= nxt_mode;
			fast_ff <= nxt_fast;
			gate_ff <= nxt_gate;
		end
	end

	// registered clock levels; stand-in uses substitute after wake
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			sys_ff <= 1'b0;
			sub_ff <= 1'b0;
			tbc_ff <= 1'b0;
		end else begin
			sys_ff <= gate_ff.sys & (fast_ff ? clk_sub : sel_clk);
			sub_ff <= gate_ff.sub & clk_sub;
			tbc_ff <= gate_ff.tbc & clk_tbc_src;
		end
	end

	// register writes
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			mc_ff <= scmc_pkg::MC_RESET;
			sc_ff <= scmc_pkg::SC_RESET;
			cf_ff <= scmc_pkg::CF_RESET;
		end else if (wr) begin
			if (hit_mc) mc_ff <= i_pwdata[7:0] & scmc_pkg::MC_WMASK;
			if (hit_sc) sc_ff <= {2'b00, i_pwdata[5:0]};
			if (hit_cf) cf_ff <= {3'b000, i_pwdata[4:0]};
		end
	end

	// read mux, mode_control bits 3/2 show oscillator states
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (hit_mc) nxt_rdata[7:0] = mc_ff |
			{4'h0, gate_ff.sub, gate_ff.hosc & ~fast_ff, 2'b00};
		if (hit_sc) nxt_rdata[7:0] = sc_ff;
		if (hit_st) nxt_rdata[7:0] = {4'h0, fast_ff, mode_ff};
		if (hit_cf) nxt_rdata[7:0] = cf_ff;
	end

	// read data captured in setup so it is stable in access
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_ff <= 32'h0000_0000;
		end else if (i_psel & ~i_penable & ~i_pwrite) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_prdata = rdata_ff;
	assign o_sys_clk = sys_ff;
	assign o_sub_clk = sub_ff;
	assign o_tbc_clk = tbc_ff;
	assign o_fast_wake = fast_ff;
	assign o_wdt_enable = wdten & (mode_ff != scmc_pkg::MODE_DEEP_SLEEP);
	assign o_gate = gate_ff;
	assign o_mode = mode_ff;
endmodule : scmc_top

// File: verif/scmc_top_props.sv
// Purpose: port-level checks of mode and clock gating for scmc_top
// Assumes: o_mode and o_gate update at the same edge
// Notes: gate bits are compared as {cpu,sys,sub,tbc}
`timescale 1ns/1ps
module scmc_top_props (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_halt,
	input wire logic i_wake,
	input wire logic o_wdt_enable,
	input scmc_pkg::scmc_gate_t o_gate,
	input scmc_pkg::scmc_mode_t o_mode
);
	// cpu halted in one of the four low power modes
	wire logic halted = o_mode >= scmc_pkg::MODE_IDLE_STOP;
	// gate view without the oscillator bit
	wire logic [3:0] g4 = {o_gate.cpu, o_gate.sys, o_gate.sub, o_gate.tbc};
	wire logic deep = o_mode == scmc_pkg::MODE_DEEP_SLEEP;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);
	property p_halt; (i_halt && !halted) |=> halted; endproperty
	a_halt: assert property (p_halt) else $error("halt ignored");
	property p_wake; (i_wake && halted) |=> !halted; endproperty
	a_wake: assert property (p_wake) else $error("wake ignored");
	property p_deep; deep |-> g4 == 4'h0 && !o_wdt_enable; endproperty
	a_deep: assert property (p_deep) else $error("deep gating");
	property p_hold; (deep && !i_wake) |=> deep; endproperty
	a_hold: assert property (p_hold) else $error("deep left");
	property p_light;
		o_mode == scmc_pkg::MODE_LIGHT_SLEEP |-> g4 == 4'h2;
	endproperty
	a_light: assert property (p_light) else $error("light gating");
	property p_idle_clock_stopped;
		o_mode == scmc_pkg::MODE_IDLE_STOP |-> g4 == 4'h3;
	endproperty
	a_idle_clock_stopped: assert property (p_idle_clock_stopped) else $error("idle_clock_stopped gating");
	property p_idle_clock_running;
		o_mode == scmc_pkg::MODE_IDLE_RUN |-> g4 == 4'h7;
	endproperty
	a_idle_clock_running: assert property (p_idle_clock_running) else $error("idle_clock_running gating");
	property p_slow;
		o_mode == scmc_pkg::MODE_SLOW |-> o_gate.cpu && !o_gate.hosc;
	endproperty
	a_slow: assert property (p_slow) else $error("slow gating");
	property p_norm;
		o_mode == scmc_pkg::MODE_NORMAL |-> g4[3] && g4[1:0] == 2'h3;
	endproperty
	a_norm: assert property (p_norm) else $error("normal gating");
endmodule : scmc_top_props

bind scmc_top scmc_top_props i_props (.i_mclk, .i_nrst, .i_halt, .i_wake,
	.o_wdt_enable, .o_gate, .o_mode);

// File: verif/tb_top.sv
// Purpose: directed bench for clock selection and low power modes
// Assumes: apb answers at once; sources held as static levels
// Notes: clock outputs are checked a few cycles after each change
`timescale 1ns/1ps
module tb_top;
	logic i_mclk = 0, i_nrst = 0, psel = 0, pen = 0, pwr = 0;
	logic halt = 0, wake = 0, rdy = 1, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwd = 0, prd, rd;
	logic high_speed_crystal = 1, high_speed_internal_rc = 0, p16 = 0, pusb = 0, low_speed_crystal = 1, low_speed_internal_rc = 0;
	logic prdy, perr, sclk, subk, tbck, fw, wdt;
	scmc_pkg::scmc_gate_t gate;
	scmc_pkg::scmc_mode_t mode;
	logic [7:0] sct [6] = '{8'h00, 8'h08, 8'h18, 8'h20, 8'h30, 8'h10};
	int errors = 0, check_count = 0;
	scmc_top i_scmc_top (.i_mclk, .i_nrst, .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd),
		.o_pready(prdy), .o_pslverr(perr), .i_hxt(high_speed_crystal), .i_high_speed_internal_rc(high_speed_internal_rc),
		.i_pll_16m(p16), .i_pll_usb(pusb), .i_lxt(low_speed_crystal), .i_low_speed_internal_rc(low_speed_internal_rc),
		.i_halt(halt), .i_wake(wake), .i_hosc_ready(rdy), .o_sys_clk(sclk),
		.o_sub_clk(subk), .o_tbc_clk(tbck), .o_fast_wake(fw),
		.o_wdt_enable(wdt), .o_gate(gate), .o_mode(mode));
	// free running 250 MHz clock
	initial begin
		forever #2 i_mclk = ~i_mclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask : cyc
	// one apb transfer, held until pready is seen; an idle edge follows
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge i_mclk);
		pen <= 1;
		@(posedge i_mclk);
		while (prdy !== 1'b1 && n < 20) begin
			@(posedge i_mclk);
			n++;
		end
		rd = prd;
		err = perr;
		psel <= 0;
		pen <= 0;
		@(posedge i_mclk);
	endtask : apb
	// reset values, writable mode control bits and an unmapped address
	task automatic t_regs;
		apb(0, scmc_pkg::ADDR_MODE_CTRL, 0);
		chk(rd & 32'h0000_00F3, 32'h0000_0003);
		apb(0, scmc_pkg::ADDR_SYS_CTRL, 0);
		chk(rd, 32'h0000_0000);
		apb(1, 8'h10, 32'hFFFF_FFFF);
		chk(err, 1);
		apb(0, 8'h10, 0);
		chk({err, rd}, {1'b1, 32'h0000_0000});
		apb(1, scmc_pkg::ADDR_MODE_CTRL, 32'h0000_00FF);
		apb(0, scmc_pkg::ADDR_MODE_CTRL, 0);
		chk(rd & 32'h0000_00F3, 32'h0000_00F3);
		apb(1, scmc_pkg::ADDR_MODE_CTRL, 32'h0000_0003);
	endtask : t_regs
	// high clock source for six of the pll / usb / 16 MHz settings
	task automatic t_hsel;
		apb(1, scmc_pkg::ADDR_CONFIG, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			apb(1, scmc_pkg::ADDR_SYS_CTRL, {24'h0, sct[i]});
			cyc(3);
			chk(sclk, i < 3);
		end
		apb(1, scmc_pkg::ADDR_CONFIG, 0);
		apb(1, scmc_pkg::ADDR_SYS_CTRL, 0);
		cyc(3);
		chk(sclk, high_speed_internal_rc);
	endtask : t_hsel
	// every divider code with the hi/lo select cleared
	task automatic t_div;
		for (int c = 0; c < 8; c++) begin
			apb(1, scmc_pkg::ADDR_MODE_CTRL, 32'(c) << 5 | 32'h0000_0002);
			cyc(2);
			chk(mode, c < 2 ? scmc_pkg::MODE_SLOW : scmc_pkg::MODE_NORMAL);
			if (c < 2) chk(gate.hosc, 0);
		end
		apb(1, scmc_pkg::ADDR_MODE_CTRL, 32'h0000_0002);
		apb(1, scmc_pkg::ADDR_CONFIG, 32'h0000_0003);
		cyc(3);
		chk(sclk, low_speed_crystal);
		apb(1, scmc_pkg::ADDR_MODE_CTRL, 32'h0000_0003);
		cyc(2);
		chk(mode, scmc_pkg::MODE_NORMAL);
	endtask : t_div
	// substitute and time base sources by configuration option
	task automatic t_sub;
		apb(1, scmc_pkg::ADDR_CONFIG, 32'h0000_0001);
		cyc(3);
		chk({subk, tbck}, 2'b00);
		apb(1, scmc_pkg::ADDR_CONFIG, 32'h0000_0005);
		cyc(3);
		chk(subk, 1);
		apb(1, scmc_pkg::ADDR_CONFIG, 32'h0000_0009);
		cyc(3);
		chk(tbck, 1);
		apb(1, scmc_pkg::ADDR_CONFIG, 32'h0000_0013);
		cyc(3);
		chk(tbck, 1);
	endtask : t_sub
	// halt with given settings, check mode, gates and watchdog, then wake
	task automatic hc(input logic [7:0] mc, input logic [7:0] sc,
		input scmc_pkg::scmc_mode_t em, input logic [4:0] eg);
		apb(1, scmc_pkg::ADDR_MODE_CTRL, {24'h0, mc});
		apb(1, scmc_pkg::ADDR_SYS_CTRL, {24'h0, sc});
		halt <= 1;
		@(posedge i_mclk);
		halt <= 0;
		cyc(2);
		chk(mode, em);
		chk({gate.cpu, gate.sys, gate.sub, gate.tbc, wdt}, eg);
		wake <= 1;
		@(posedge i_mclk);
		wake <= 0;
		cyc(2);
		chk(mode, scmc_pkg::MODE_NORMAL);
	endtask : hc
	// fast wake from idle, cleared by oscillator ready; none from deep
	task automatic t_fast;
		rdy <= 0;
		hc(8'h13, 8'h00, scmc_pkg::MODE_IDLE_STOP, 5'b00110);
		chk(fw, 1);
		rdy <= 1;
		cyc(3);
		chk(fw, 0);
		rdy <= 0;
		hc(8'h11, 8'h00, scmc_pkg::MODE_DEEP_SLEEP, 5'b00000);
		chk(fw, 0);
		rdy <= 1;
	endtask : t_fast
	task automatic print_verdict;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	// watchdog against a hung handshake
	initial begin
		#100000;
		errors++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge i_mclk);
		i_nrst <= 1;
		t_regs;
		t_hsel;
		t_div;
		t_sub;
		// mode control 8'h01: hi select set, idle on halt cleared
		hc(8'h01, 8'h00, scmc_pkg::MODE_DEEP_SLEEP, 5'b00000);
		hc(8'h01, 8'h02, scmc_pkg::MODE_LIGHT_SLEEP, 5'b00100);
		hc(8'h01, 8'h04, scmc_pkg::MODE_LIGHT_SLEEP, 5'b00101);
		hc(8'h03 | 8'h02, 8'h00, scmc_pkg::MODE_IDLE_STOP, 5'b00110);
		hc(8'h03, 8'h01, scmc_pkg::MODE_IDLE_RUN, 5'b01110);
		hc(8'h01, 8'h01, scmc_pkg::MODE_DEEP_SLEEP, 5'b00000);
		hc(8'h03 & 8'h03 | 8'h02, 8'h00, scmc_pkg::MODE_IDLE_STOP, 5'b00110);
		t_fast;
		print_verdict;
	end
endmodule : tb_top
